// file: hdl/i2c_controller.sv
// serial link master: clock divider, conditions, one-byte transfers
module i2c_controller (
  i2c_link_if.ctrl l,
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_go,
  input wire logic [6:0] i_addr,
  input wire logic i_rw,
  input wire logic [7:0] i_wdata,
  input wire logic i_fast,
  input wire logic i_hs,
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic o_lost,
  output logic [7:0] o_rdata
);

  // ----------------------------------------------------------------
  // line sampling: bit 0 clock, bit 1 data
  // ----------------------------------------------------------------
  logic [1:0] pin_m;
  logic [1:0] pin_s;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      pin_m <= 2'h3;
      pin_s <= 2'h3;
    end else begin
      pin_m <= {l.sda, l.scl};
      pin_s <= pin_m;
    end
  end

  // ----------------------------------------------------------------
  // quarter-bit divider
  // ----------------------------------------------------------------
  i2c_pkg::mst_state_t st_r;
  i2c_pkg::byte_sel_t bsel_r;
  logic [7:0] qcnt_r;
  logic [1:0] ph_r;
  logic scl_hi_r;
  logic sda_hi_r;
  logic hs_r;
  logic fast_r;
  logic hs_req_r;
  logic rw_r;
  logic [6:0] addr_r;
  logic [7:0] wdata_r;
  logic [8:0] sh_r;
  logic [8:0] rx_r;
  logic [3:0] bitn_r;
  logic [7:0] qlim;
  logic hold;
  logic tick;

  assign qlim = hs_r ? 8'(i2c_pkg::HS_Q) :
                (fast_r ? 8'(i2c_pkg::FAST_Q) : 8'(i2c_pkg::STD_Q));
  // a target holding the clock low freezes the bit timing
  assign hold = scl_hi_r & ~pin_s[0];
  assign tick = st_r != i2c_pkg::M_IDLE && qcnt_r == 8'h00 && !hold;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      qcnt_r <= 8'h00;
    end else if (st_r == i2c_pkg::M_IDLE || hold) begin
      qcnt_r <= qcnt_r;
    end else if (qcnt_r == 8'h00) begin
      qcnt_r <= qlim - 8'h01;
    end else begin
      qcnt_r <= qcnt_r - 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // transfer sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      st_r <= i2c_pkg::M_IDLE;
      bsel_r <= i2c_pkg::B_ADDR;
      ph_r <= 2'h0;
      scl_hi_r <= 1'b1;
      sda_hi_r <= 1'b1;
      hs_r <= 1'b0;
      fast_r <= 1'b0;
      hs_req_r <= 1'b0;
      rw_r <= 1'b0;
      addr_r <= 7'h00;
      wdata_r <= 8'h00;
      sh_r <= 9'h1ff;
      rx_r <= 9'h000;
      bitn_r <= 4'h0;
      o_done <= 1'b0;
      o_nack <= 1'b0;
      o_lost <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      o_done <= 1'b0;
      if (st_r == i2c_pkg::M_IDLE) begin
        if (i_go) begin
          st_r <= i2c_pkg::M_START;
          bsel_r <= i_hs ? i2c_pkg::B_HS : i2c_pkg::B_ADDR;
          ph_r <= 2'h0;
          fast_r <= i_fast;
          hs_req_r <= i_hs;
          rw_r <= i_rw;
          addr_r <= i_addr;
          wdata_r <= i_wdata;
          o_nack <= 1'b0;
          o_lost <= 1'b0;
        end
      end else if (tick) begin
        ph_r <= ph_r + 2'h1;
        unique case (st_r)
          i2c_pkg::M_START: begin
            unique case (ph_r)
              2'h0: sda_hi_r <= 1'b1;
              2'h1: scl_hi_r <= 1'b1;
              2'h2: begin
                if (!pin_s[1] || !pin_s[0]) begin
                  // data low at the rise or clock lost first: collision
                  o_lost <= 1'b1;
                  o_done <= 1'b1;
                  st_r <= i2c_pkg::M_IDLE;
                end else begin
                  sda_hi_r <= 1'b0;
                end
              end
              2'h3: begin
                scl_hi_r <= 1'b0;
                st_r <= i2c_pkg::M_BYTE;
                bitn_r <= 4'h0;
                sh_r <= bsel_r == i2c_pkg::B_HS ? {i2c_pkg::HS_CODE, 1'b1} : {addr_r, rw_r, 1'b1};
              end
            endcase
          end
          i2c_pkg::M_BYTE: begin
            unique case (ph_r)
              2'h0: sda_hi_r <= sh_r[8];
              2'h1: scl_hi_r <= 1'b1;
              2'h2: begin
                rx_r <= {rx_r[7:0], pin_s[1]};
                if (sh_r[8] && !pin_s[1] && bitn_r != i2c_pkg::BYTE_BITS &&
                    !(bsel_r == i2c_pkg::B_DATA && rw_r)) begin
                  // another master won: let go of both lines
                  o_lost <= 1'b1;
                  o_done <= 1'b1;
                  scl_hi_r <= 1'b1;
                  sda_hi_r <= 1'b1;
                  hs_r <= 1'b0;
                  st_r <= i2c_pkg::M_IDLE;
                end
              end
              2'h3: begin
                scl_hi_r <= 1'b0;
                sh_r <= {sh_r[7:0], 1'b1};
                bitn_r <= bitn_r + 4'h1;
                if (bitn_r == i2c_pkg::BYTE_BITS) begin
                  bitn_r <= 4'h0;
                  unique case (bsel_r)
                    i2c_pkg::B_HS: begin
                      hs_r <= 1'b1;
                      bsel_r <= i2c_pkg::B_ADDR;
                      st_r <= i2c_pkg::M_START;
                    end
                    i2c_pkg::B_ADDR: begin
                      if (rx_r[0]) begin
                        o_nack <= 1'b1;
                        st_r <= i2c_pkg::M_STOP;
                      end else begin
                        bsel_r <= i2c_pkg::B_DATA;
                        sh_r <= rw_r ? 9'h1ff : {wdata_r, 1'b1};
                      end
                    end
                    i2c_pkg::B_DATA: begin
                      if (rw_r) begin
                        o_rdata <= rx_r[8:1];
                      end else begin
                        o_nack <= rx_r[0];
                      end
                      st_r <= i2c_pkg::M_STOP;
                    end
                    default: st_r <= i2c_pkg::M_STOP;
                  endcase
                end
              end
            endcase
          end
          i2c_pkg::M_STOP: begin
            unique case (ph_r)
              2'h0: sda_hi_r <= 1'b0;
              2'h1: scl_hi_r <= 1'b1;
              2'h2: sda_hi_r <= 1'b1;
              2'h3: begin
                hs_r <= 1'b0;
                o_done <= 1'b1;
                st_r <= i2c_pkg::M_IDLE;
              end
            endcase
          end
          default: st_r <= i2c_pkg::M_IDLE;
        endcase
      end
    end
  end

  assign l.m_scl_o = 1'b0;
  assign l.m_scl_oe = ~scl_hi_r;
  assign l.m_sda_o = 1'b0;
  assign l.m_sda_oe = ~sda_hi_r;
  assign o_busy = st_r != i2c_pkg::M_IDLE;

endmodule : i2c_controller

// file: hdl/i2c_pkg.sv
// constants and types shared by both ends of the two-wire link
package i2c_pkg;

  // ----------------------------------------------------------------
  // clock and bit rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned STD_HZ = 100_000;
  localparam int unsigned FAST_HZ = 400_000;
  localparam int unsigned HS_HZ = 3_400_000;
  // clock cycles per quarter bit, rounded up so no rate is exceeded
  localparam int unsigned STD_Q = (CLK_HZ + 4 * STD_HZ - 1) / (4 * STD_HZ);
  localparam int unsigned FAST_Q = (CLK_HZ + 4 * FAST_HZ - 1) / (4 * FAST_HZ);
  localparam int unsigned HS_Q = (CLK_HZ + 4 * HS_HZ - 1) / (4 * HS_HZ);

  // ----------------------------------------------------------------
  // byte formats
  // ----------------------------------------------------------------
  localparam logic [6:0] TARGET_ADDR_DEF = 7'h4c;
  localparam logic [7:0] GEN_CALL = 8'h00;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [7:0] HS_CODE = 8'h08;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT = 4'h9;

  // ----------------------------------------------------------------
  // states and event kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {T_IDLE, T_ADDR, T_ACK, T_WR, T_RD, T_IGNORE} tgt_state_t;
  typedef enum logic [1:0] {M_IDLE, M_START, M_BYTE, M_STOP} mst_state_t;
  typedef enum logic [1:0] {B_HS, B_ADDR, B_DATA} byte_sel_t;
  typedef enum logic [1:0] {EV_ADDR, EV_DATA, EV_ABORT, EV_STOP} ev_kind_t;

endpackage : i2c_pkg

// file: hdl/i2c_link_if.sv
// two-wire link with open-drain resolution of both lines
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_scl_o;
  logic t_scl_oe;
  logic t_sda_o;
  logic t_sda_oe;
  wire logic scl;
  wire logic sda;

  // pulled up unless an enabled driver pulls low
  assign scl = (m_scl_oe ? m_scl_o : 1'b1) & (t_scl_oe ? t_scl_o : 1'b1);
  assign sda = (m_sda_oe ? m_sda_o : 1'b1) & (t_sda_oe ? t_sda_o : 1'b1);

  modport ctrl (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
  modport tgt (input scl, input sda, output t_scl_o, output t_scl_oe,
               output t_sda_o, output t_sda_oe);
endinterface : i2c_link_if

// file: hdl/i2c_target.sv
// serial link target: condition detection, address match, acknowledge
module i2c_target #(
  parameter logic [6:0] TARGET_ADDR = i2c_pkg::TARGET_ADDR_DEF
) (
  i2c_link_if.tgt l,
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_link_clk,
  output logic o_addr_valid,
  output logic o_rx_valid,
  output logic o_abort,
  output logic o_stop,
  output logic [7:0] o_byte,
  output logic o_hs_mode
);

  // ----------------------------------------------------------------
  // link domain reset
  // ----------------------------------------------------------------
  logic lrst_m;
  logic lrst;

  always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      lrst_m <= 1'b1;
      lrst <= 1'b1;
    end else begin
      lrst_m <= 1'b0;
      lrst <= lrst_m;
    end
  end

  // ----------------------------------------------------------------
  // line input: bit 0 clock, bit 1 data
  // ----------------------------------------------------------------
  logic [1:0] in_m;
  logic [1:0] in_s;
  logic [1:0] in_d;
  logic [1:0] in_f;
  logic [1:0] in_q;

  always_ff @(posedge i_link_clk or posedge lrst) begin
    if (lrst) begin
      in_m <= 2'h3;
      in_s <= 2'h3;
      in_d <= 2'h3;
      in_f <= 2'h3;
      in_q <= 2'h3;
    end else begin
      in_m <= {l.sda, l.scl};
      in_s <= in_m;
      in_d <= in_s;
      // one-sample spikes never reach the filtered level
      in_f <= (in_s & in_d) | (in_f & (in_s | in_d));
      in_q <= in_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise = in_f[0] & ~in_q[0];
  assign scl_fall = ~in_f[0] & in_q[0];
  // data moving under a high clock is a condition, never a bit
  assign start_det = in_f[0] & in_q[0] & in_q[1] & ~in_f[1];
  assign stop_det = in_f[0] & in_q[0] & ~in_q[1] & in_f[1];

  // ----------------------------------------------------------------
  // link state machine
  // ----------------------------------------------------------------
  i2c_pkg::tgt_state_t st_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic rw_r;
  logic sda_oe_r;
  logic hs_r;
  logic ev_tgl_r;
  i2c_pkg::ev_kind_t ev_kind_r;
  logic [7:0] ev_byte_r;
  logic mid_byte;
  logic addr_hit;

  // the clock rise under a condition is counted too: a cut byte shows two or more
  assign mid_byte = (st_r == i2c_pkg::T_ADDR || st_r == i2c_pkg::T_WR) && cnt_r > 4'h1;
  assign addr_hit = sh_r[7:1] == TARGET_ADDR || sh_r == i2c_pkg::GEN_CALL;

  always_ff @(posedge i_link_clk or posedge lrst) begin
    if (lrst) begin
      st_r <= i2c_pkg::T_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ev_tgl_r <= 1'b0;
      ev_kind_r <= i2c_pkg::EV_STOP;
      ev_byte_r <= 8'h00;
    end else if (start_det) begin
      // start or repeated start: drop whatever was under way
      st_r <= i2c_pkg::T_ADDR;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      if (mid_byte) begin
        ev_tgl_r <= ~ev_tgl_r;
        ev_kind_r <= i2c_pkg::EV_ABORT;
      end
    end else if (stop_det) begin
      st_r <= i2c_pkg::T_IDLE;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      ev_tgl_r <= ~ev_tgl_r;
      ev_kind_r <= mid_byte ? i2c_pkg::EV_ABORT : i2c_pkg::EV_STOP;
    end else begin
      unique case (st_r)
        i2c_pkg::T_IDLE, i2c_pkg::T_IGNORE: begin
        end
        i2c_pkg::T_ADDR, i2c_pkg::T_WR: begin
          if (scl_rise) begin
            sh_r <= {sh_r[6:0], in_f[1]};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == i2c_pkg::BYTE_BITS) begin
            cnt_r <= 4'h0;
            if (st_r == i2c_pkg::T_WR) begin
              sda_oe_r <= 1'b1;
              st_r <= i2c_pkg::T_ACK;
              ev_tgl_r <= ~ev_tgl_r;
              ev_kind_r <= i2c_pkg::EV_DATA;
              ev_byte_r <= sh_r;
            end else if (addr_hit) begin
              sda_oe_r <= 1'b1;
              rw_r <= sh_r[0];
              st_r <= i2c_pkg::T_ACK;
              ev_tgl_r <= ~ev_tgl_r;
              ev_kind_r <= i2c_pkg::EV_ADDR;
              ev_byte_r <= sh_r;
            end else begin
              // foreign address or mode code: leave data released
              st_r <= i2c_pkg::T_IGNORE;
            end
          end
        end
        i2c_pkg::T_ACK: begin
          if (scl_fall) begin
            sda_oe_r <= 1'b0;
            st_r <= rw_r ? i2c_pkg::T_RD : i2c_pkg::T_WR;
          end
        end
        i2c_pkg::T_RD: begin
          // sends all ones, so data stays released; watches master reply
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == i2c_pkg::BYTE_BITS) begin
              cnt_r <= 4'h0;
              if (in_f[1]) begin
                st_r <= i2c_pkg::T_IGNORE;
              end
            end
          end
        end
      endcase
    end
  end

  // mode code 0000_1xxx seen after start holds until the next stop
  always_ff @(posedge i_link_clk or posedge lrst) begin
    if (lrst) begin
      hs_r <= 1'b0;
    end else if (stop_det) begin
      hs_r <= 1'b0;
    end else if (st_r == i2c_pkg::T_ADDR && scl_fall && cnt_r == i2c_pkg::BYTE_BITS &&
                 sh_r[7:3] == i2c_pkg::HS_CODE_TOP) begin
      hs_r <= 1'b1;
    end
  end

  // only ever pulls data low between clock falls, never the clock
  assign l.t_sda_o = 1'b0;
  assign l.t_sda_oe = sda_oe_r;
  assign l.t_scl_o = 1'b0;
  assign l.t_scl_oe = 1'b0;

  // ----------------------------------------------------------------
  // crossing to the system clock
  // ----------------------------------------------------------------
  logic tg_m;
  logic tg_s;
  logic tg_d;
  logic hs_m;
  logic hs_s;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tg_m <= 1'b0;
      tg_s <= 1'b0;
      tg_d <= 1'b0;
      hs_m <= 1'b0;
      hs_s <= 1'b0;
    end else begin
      tg_m <= ev_tgl_r;
      tg_s <= tg_m;
      tg_d <= tg_s;
      hs_m <= hs_r;
      hs_s <= hs_m;
    end
  end

  // kind and byte are held still long before the toggle lands here
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_addr_valid <= 1'b0;
      o_rx_valid <= 1'b0;
      o_abort <= 1'b0;
      o_stop <= 1'b0;
      o_byte <= 8'h00;
    end else begin
      o_addr_valid <= (tg_s ^ tg_d) && ev_kind_r == i2c_pkg::EV_ADDR;
      o_rx_valid <= (tg_s ^ tg_d) && ev_kind_r == i2c_pkg::EV_DATA;
      o_abort <= (tg_s ^ tg_d) && ev_kind_r == i2c_pkg::EV_ABORT;
      o_stop <= (tg_s ^ tg_d) && ev_kind_r == i2c_pkg::EV_STOP;
      if (tg_s ^ tg_d) begin
        o_byte <= ev_byte_r;
      end
    end
  end

  assign o_hs_mode = hs_s;

endmodule : i2c_target

// file: sim/i2c_link_chk.sv
// concurrent checks on the two-wire link between controller and target
module i2c_link_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic t_scl_oe,
  input wire logic t_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // link assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_tgt_no_stretch: assert property (!t_scl_oe)
    else $error("target pulled the clock line");
  a_drive_only_low: assert property (sda || m_sda_oe || t_sda_oe)
    else $error("data low with no driver enabled");
  a_clk_low_driven: assert property (scl || m_scl_oe || t_scl_oe)
    else $error("clock low with no driver enabled");
  a_ack_clk_low: assert property ($changed(t_sda_oe) |-> !scl)
    else $error("target changed data with clock high");
  a_ack_stands: assert property ($rose(t_sda_oe) |-> t_sda_oe [*8])
    else $error("acknowledge drive too short");
  a_ack_spans_high: assert property ($rose(t_sda_oe) |-> ##[1:400] (scl && t_sda_oe))
    else $error("acknowledge not held over clock high");
  a_one_line_moves: assert property ($changed(m_sda_oe) |-> $stable(m_scl_oe))
    else $error("master moved both lines at once");
  a_start_then_low: assert property (scl && $fell(sda) |-> ##[1:130] !scl)
    else $error("clock not lowered after start");
  a_stop_quiet: assert property (scl && $rose(sda) |-> (scl && sda) [*8])
    else $error("bus not released after stop");
  a_scl_by_master: assert property ($fell(scl) |-> m_scl_oe)
    else $error("clock fell without master drive");

  c_ack: cover property ($rose(t_sda_oe));
  c_start: cover property (scl && $fell(sda));
  c_stop: cover property (scl && $rose(sda));
endmodule : i2c_link_chk

// file: sim/i2c_slave_bus_interface_test.sv
// self-checking bench: controller and target on one link, target alone on a bit-banged link
module i2c_slave_bus_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic link_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic go = 1'b0;
  logic [6:0] addr = 7'h00;
  logic rw = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic fast = 1'b0;
  logic hs = 1'b0;
  logic busy, done, nack, lost, addr_v, rx_v, abort, stop, hs_mode;
  logic addr_v2, rx_v2, abort2, stop2;
  logic [7:0] rdata, rx_byte, rx_byte2;
  logic [15:0] got_q[$];
  logic [15:0] got2_q[$];
  logic [15:0] exp_q[$];
  logic want_stop = 1'b0;
  logic hs_seen = 1'b0;
  int fails = 0;
  int n_tests = 0;

  i2c_link_if lnk();
  i2c_link_if lnk2();

  i2c_controller i_i2c_controller (.l(lnk), .i_clk(clk), .i_sys_rst(sys_rst), .i_go(go),
    .i_addr(addr), .i_rw(rw), .i_wdata(wdata), .i_fast(fast), .i_hs(hs), .o_busy(busy),
    .o_done(done), .o_nack(nack), .o_lost(lost), .o_rdata(rdata));
  i2c_target #(.TARGET_ADDR(i2c_pkg::TARGET_ADDR_DEF)) i_i2c_target (.l(lnk), .i_clk(clk),
    .i_sys_rst(sys_rst), .i_link_clk(link_clk), .o_addr_valid(addr_v), .o_rx_valid(rx_v),
    .o_abort(abort), .o_stop(stop), .o_byte(rx_byte), .o_hs_mode(hs_mode));
  i2c_target #(.TARGET_ADDR(i2c_pkg::TARGET_ADDR_DEF)) i_i2c_target_b (.l(lnk2), .i_clk(clk),
    .i_sys_rst(sys_rst), .i_link_clk(link_clk), .o_addr_valid(addr_v2), .o_rx_valid(rx_v2),
    .o_abort(abort2), .o_stop(stop2), .o_byte(rx_byte2), .o_hs_mode());
  i2c_link_chk i_i2c_link_chk (.i_clk(clk), .i_sys_rst(sys_rst),
    .m_scl_oe(lnk.m_scl_oe), .m_sda_oe(lnk.m_sda_oe), .t_scl_oe(lnk.t_scl_oe),
    .t_sda_oe(lnk.t_sda_oe), .scl(lnk.scl), .sda(lnk.sda));

  initial forever #10 clk = ~clk;
  initial begin
    #1.3;
    forever #3 link_clk = ~link_clk;
  end

  // ----------------------------------------------------------------
  // event monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (addr_v === 1'b1) got_q.push_back({8'h01, rx_byte});
    if (rx_v === 1'b1) got_q.push_back({8'h02, rx_byte});
    if (abort === 1'b1) got_q.push_back(16'h0300);
    if (stop === 1'b1 && want_stop) got_q.push_back(16'h0400);
    if (hs_mode === 1'b1) hs_seen = 1'b1;
    if (addr_v2 === 1'b1) got2_q.push_back({8'h01, rx_byte2});
    if (rx_v2 === 1'b1) got2_q.push_back({8'h02, rx_byte2});
    if (abort2 === 1'b1) got2_q.push_back(16'h0300);
    if (stop2 === 1'b1) got2_q.push_back(16'h0400);
  end

  // ----------------------------------------------------------------
  // comparison and closing
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task cmp_q(input bit second);
    logic [15:0] g;
    check(32'(second ? got2_q.size() : got_q.size()), 32'(exp_q.size()));
    while (exp_q.size() > 0 && (second ? got2_q.size() : got_q.size()) > 0) begin
      g = second ? got2_q.pop_front() : got_q.pop_front();
      check(32'(g), 32'(exp_q.pop_front()));
    end
    exp_q.delete();
    got_q.delete();
    got2_q.delete();
  endtask : cmp_q

  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    test_done();
  end

  // ----------------------------------------------------------------
  // controller transfer with model of the target's answer
  // ----------------------------------------------------------------
  task xfer(input logic [6:0] a, input logic r, input logic [7:0] d, input logic f,
            input logic h);
    logic ack;
    int k;
    ack = (a == i2c_pkg::TARGET_ADDR_DEF) || (a == 7'h00 && !r);
    if (ack) exp_q.push_back({8'h01, a, r});
    if (ack && !r) exp_q.push_back({8'h02, d});
    if (ack) exp_q.push_back(16'h0400);
    want_stop = ack;
    hs_seen = 1'b0;
    @(posedge clk);
    #1;
    addr = a;
    rw = r;
    wdata = d;
    fast = f;
    hs = h;
    go = 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (busy !== 1'b1 && k < 10);
    go = 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 20000);
    check(32'(done), 32'h1);
    check(32'(nack), 32'(!ack));
    check(32'(lost), 32'h0);
    if (ack && r) check(32'(rdata), 32'hff);
    repeat (30) @(posedge clk);
    // an address byte of the form 0000_1xxx is itself the high speed code
    check(32'(hs_seen), 32'(h || a[6:2] == i2c_pkg::HS_CODE_TOP));
    check(32'(hs_mode), 32'h0);
    cmp_q(1'b0);
  endtask : xfer

  // ----------------------------------------------------------------
  // bit-banged master on the second link
  // ----------------------------------------------------------------
  task put(input logic c, input logic d);
    repeat (10) @(posedge clk);
    #1;
    lnk2.m_scl_oe = !c;
    lnk2.m_sda_oe = !d;
  endtask : put

  task bb_start(input logic rep);
    if (rep) put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
    put(1'b0, 1'b0);
  endtask : bb_start

  task bb_bits(input logic [7:0] v, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      put(1'b0, v[i]);
      put(1'b1, v[i]);
      put(1'b0, v[i]);
    end
  endtask : bb_bits

  task bb_ack;
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
    repeat (5) @(posedge clk);
    check(32'(lnk2.sda), 32'h0);
    put(1'b0, 1'b1);
  endtask : bb_ack

  task bb_stop;
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask : bb_stop

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [6:0] a;
    lnk2.m_scl_o = 1'b0;
    lnk2.m_sda_o = 1'b0;
    lnk2.m_scl_oe = 1'b0;
    lnk2.m_sda_oe = 1'b0;
    void'($urandom(46));
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 12; i++) begin
      a = (i % 3 == 0) ? i2c_pkg::TARGET_ADDR_DEF : (i % 3 == 1) ? 7'h00 : 7'($urandom);
      xfer(a, 1'($urandom), 8'($urandom), 1'(i % 2), 1'(i % 4 == 3));
    end
    // stop cuts the address byte
    bb_start(1'b0);
    bb_bits({i2c_pkg::TARGET_ADDR_DEF, 1'b0}, 3);
    bb_stop();
    exp_q.push_back(16'h0300);
    // repeated start cuts a data byte, then readdressing
    bb_start(1'b0);
    bb_bits({i2c_pkg::TARGET_ADDR_DEF, 1'b0}, 8);
    bb_ack();
    bb_bits(8'ha5, 3);
    bb_start(1'b1);
    bb_bits({i2c_pkg::TARGET_ADDR_DEF, 1'b0}, 8);
    bb_ack();
    bb_stop();
    exp_q.push_back({8'h01, i2c_pkg::TARGET_ADDR_DEF, 1'b0});
    exp_q.push_back(16'h0300);
    exp_q.push_back({8'h01, i2c_pkg::TARGET_ADDR_DEF, 1'b0});
    exp_q.push_back(16'h0400);
    repeat (30) @(posedge clk);
    cmp_q(1'b1);
    test_done();
  end
endmodule : i2c_slave_bus_interface_test
